//--- verilog/uus_top.sv
`timescale 1ns/1ns
`default_nettype none
module uus_top
  import uus_pkg::*;
#(
  parameter int unsigned MS_CYC_P = MS_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [VW-1:0] writedata,
  input wire logic [BW-1:0] byteenable,
  output logic [VW-1:0] readdata,
  output logic waitrequest,
  input wire logic [VW-1:0] act_pos_in,
  input wire logic [VW-1:0] act_spd_in,
  input wire logic lim_neg_in,
  input wire logic lim_pos_in,
  output logic [VW-1:0] dem_pos,
  output logic [VW-1:0] spd_int,
  output logic [VW-1:0] acc_int,
  output logic [VW-1:0] jerk_int,
  output logic conv_valid,
  output logic quick_stop,
  output logic fault,
  output logic loop_tick
);
  typedef struct packed {
    logic wt;
    logic [VW-1:0] rdata;
    logic [1:0] ctrl;
    logic [NFAC-1:0][FW-1:0] fac, sfac;
    logic [VW-1:0] tol, swmin, swmax, tgt, spd, acc, jerk;
    logic [MW-1:0] mode, smode;
    logic [VW-1:0] s_tgt, s_spd, s_acc, s_jerk, s_apos, s_aspd, lo, hi;
    logic neg_zone, pos_zone;
    logic [VW-1:0] neg_edge, pos_edge, apos_u, aspd_u, dem, spd_i, acc_i, jerk_i;
    logic fault, qstop, rej, valid, start, ltick;
    uus_job_t job;
    logic [VW-1:0] ms_cnt;
    logic [LW-1:0] l_cnt;
  } uus_state_t;

  uus_state_t st_r;
  uus_state_t st_nxt;

  logic [DW-1:0] pm, pd;
  logic [VW-1:0] div_val;
  logic [DW-1:0] div_mul, div_den;
  logic [VW-1:0] mag;
  logic [NW-1:0] div_num, quo;
  logic div_done;
  logic [VW-1:0] res, rd, fac_rd;
  logic ms_tick, neg_sw, pos_sw, neg_bad, pos_bad;

  // user-to-internal position factor: increments x feed / (revolutions x gear)
  always_comb begin
    pm = DW'(uus_nz(st_r.sfac[F_ENC])) * DW'(uus_nz(st_r.sfac[F_FEED]))
         * DW'(uus_nz(st_r.sfac[F_GSHAFT])); // R3 R6
    pd = DW'(uus_nz(st_r.sfac[F_MREV])) * DW'(uus_nz(st_r.sfac[F_FSHAFT]))
         * DW'(uus_nz(st_r.sfac[F_GMOT])); // R3 R6
    div_val = '0;
    div_mul = '0;
    div_den = DW'(ONE);
    unique case (st_r.job)
      J_IDLE: div_val = '0;
      J_TGT: begin
        div_val = st_r.s_tgt;
        div_mul = pm; // R6
        div_den = pd;
      end
      J_APOS: begin
        div_val = st_r.s_apos;
        div_mul = pd; // R6
        div_den = pm;
      end
      J_SPD: begin
        div_val = st_r.s_spd;
        div_mul = DW'(uus_nz(st_r.sfac[F_SNUM])); // R7
        div_den = DW'(uus_nz(st_r.sfac[F_SDEN]));
      end
      J_ASPD: begin
        div_val = st_r.s_aspd;
        div_mul = DW'(uus_nz(st_r.sfac[F_SDEN])); // R8
        div_den = DW'(uus_nz(st_r.sfac[F_SNUM]));
      end
      J_ACC: begin
        div_val = st_r.s_acc;
        div_mul = DW'(uus_nz(st_r.sfac[F_ANUM])); // R10
        div_den = DW'(uus_nz(st_r.sfac[F_ADEN]));
      end
      J_JERK: begin
        div_val = st_r.s_jerk;
        div_mul = DW'(uus_nz(st_r.sfac[F_JNUM])); // R11
        div_den = DW'(uus_nz(st_r.sfac[F_JDEN]));
      end
    endcase
    mag = div_val[VW-1] ? -div_val : div_val;
    // half the divisor added to the magnitude rounds to nearest, ties away from zero
    div_num = NW'(mag) * NW'(div_mul) + NW'(div_den >> 1); // R19
    if (quo > NW'(VMAX)) begin
      res = div_val[VW-1] ? VNEG : VMAX;
    end else begin
      res = div_val[VW-1] ? -quo[VW-1:0] : quo[VW-1:0];
    end
  end

  always_comb begin
    ms_tick = (st_r.ms_cnt == VW'(MS_CYC_P - 1));
    neg_sw = lim_neg_in && st_r.ctrl[C_NEG_EN]; // R12
    pos_sw = lim_pos_in && st_r.ctrl[C_POS_EN]; // R12
    neg_bad = st_r.neg_zone && neg_sw
              && ($signed(act_pos_in) < $signed(st_r.neg_edge - st_r.tol)); // R13
    pos_bad = st_r.pos_zone && pos_sw
              && ($signed(act_pos_in) > $signed(st_r.pos_edge + st_r.tol)); // R13
  end

  always_comb begin
    fac_rd = '0;
    for (int i = 0; i < NFAC; i++) begin
      if (address == A_FAC0 + AW'(i)) fac_rd = VW'(st_r.fac[i]);
    end
    case (address)
      A_CTRL: rd = VW'(st_r.ctrl);
      A_STAT: rd = VW'({st_r.job != J_IDLE, st_r.rej, st_r.pos_zone, st_r.neg_zone, st_r.fault});
      A_TOL: rd = st_r.tol;
      A_SWMIN: rd = st_r.swmin;
      A_SWMAX: rd = st_r.swmax;
      A_TGT: rd = st_r.tgt;
      A_SPD: rd = st_r.spd;
      A_ACC: rd = st_r.acc;
      A_JERK: rd = st_r.jerk;
      A_MODE: rd = VW'(st_r.mode);
      A_APOS: rd = st_r.apos_u;
      A_ASPD: rd = st_r.aspd_u;
      A_DEM: rd = st_r.dem;
      default: rd = fac_rd;
    endcase
  end

  always_comb begin
    logic [VW-1:0] wv;
    wv = '0;
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    st_nxt.valid = 1'b0;
    st_nxt.qstop = 1'b0;
    st_nxt.ltick = 1'b0;
    // every access answers on the second edge; a slower slave is not needed here
    st_nxt.wt = 1'b1;
    if ((read || write) && st_r.wt) begin
      st_nxt.wt = 1'b0;
      st_nxt.rdata = read ? rd : '0;
    end
    if (write && !st_r.wt) begin
      wv = uus_bemerge(rd, writedata, byteenable);
      for (int i = 0; i < NFAC; i++) begin
        if (address == A_FAC0 + AW'(i)) st_nxt.fac[i] = wv[FW-1:0];
      end
      case (address)
        A_CTRL: begin
          st_nxt.ctrl = wv[C_POS_EN:C_NEG_EN];
          if (wv[C_FCLR]) begin
            st_nxt.fault = 1'b0;
            st_nxt.rej = 1'b0;
          end
        end
        A_TOL: st_nxt.tol = wv;
        A_SWMIN: st_nxt.swmin = wv;
        A_SWMAX: st_nxt.swmax = wv;
        A_TGT: st_nxt.tgt = wv;
        A_SPD: st_nxt.spd = wv;
        A_ACC: st_nxt.acc = wv;
        A_JERK: st_nxt.jerk = wv;
        A_MODE: st_nxt.mode = wv[MW-1:0];
        default: ;
      endcase
    end

    st_nxt.l_cnt = st_r.l_cnt + 1'b1;
    if (st_r.l_cnt == LW'(LOOP_CYC - 1)) begin
      st_nxt.l_cnt = '0;
      st_nxt.ltick = 1'b1; // R18
    end

    // the drive-side inputs are looked at only here, so faster changes are missed; the bus is served every cycle
    st_nxt.ms_cnt = st_r.ms_cnt + 1'b1;
    if (ms_tick) begin
      st_nxt.ms_cnt = '0;
      if (!neg_sw) begin
        st_nxt.neg_zone = 1'b0;
      end else if (!st_r.neg_zone) begin
        st_nxt.neg_zone = 1'b1;
        st_nxt.neg_edge = act_pos_in; // R13
      end
      if (!pos_sw) begin
        st_nxt.pos_zone = 1'b0;
      end else if (!st_r.pos_zone) begin
        st_nxt.pos_zone = 1'b1;
        st_nxt.pos_edge = act_pos_in; // R13
      end
      if (neg_bad || pos_bad) begin
        st_nxt.fault = 1'b1; // R14
        st_nxt.qstop = 1'b1;
      end
      // a tick that finds the chain still busy is skipped, not queued
      if (st_r.job == J_IDLE) begin
        st_nxt.sfac = st_r.fac; // R17
        st_nxt.s_tgt = st_r.tgt;
        st_nxt.s_spd = st_r.spd;
        st_nxt.s_acc = st_r.acc;
        st_nxt.s_jerk = st_r.jerk;
        st_nxt.s_apos = act_pos_in;
        st_nxt.s_aspd = act_spd_in;
        st_nxt.smode = st_r.mode;
        st_nxt.lo = st_r.swmin;
        st_nxt.hi = st_r.swmax;
        st_nxt.job = J_TGT;
        st_nxt.start = 1'b1;
      end
    end

    if (div_done) begin
      st_nxt.start = 1'b1;
      unique case (st_r.job)
        J_IDLE: st_nxt.start = 1'b0;
        J_TGT: begin
          if (($signed(st_r.s_apos) > $signed(st_r.hi) && $signed(res) > $signed(st_r.s_apos))
              || ($signed(st_r.s_apos) < $signed(st_r.lo) && $signed(res) < $signed(st_r.s_apos))) begin
            st_nxt.rej = 1'b1; // R16
          end else if ($signed(res) > $signed(st_r.hi)) begin
            st_nxt.dem = st_r.hi; // R15
          end else if ($signed(res) < $signed(st_r.lo)) begin
            st_nxt.dem = st_r.lo; // R15
          end else begin
            st_nxt.dem = res;
          end
          st_nxt.job = J_APOS;
        end
        J_APOS: begin
          st_nxt.apos_u = res;
          st_nxt.job = J_SPD;
        end
        J_SPD: begin
          st_nxt.spd_i = res; // R7
          st_nxt.job = J_ASPD;
        end
        J_ASPD: begin
          st_nxt.aspd_u = res; // R8
          st_nxt.job = J_ACC;
        end
        J_ACC: begin
          st_nxt.acc_i = res; // R10
          st_nxt.job = J_JERK;
        end
        J_JERK: begin
          st_nxt.jerk_i = (st_r.smode == MODE_PP || st_r.smode == MODE_PV) ? res : '0; // R11
          st_nxt.job = J_IDLE;
          st_nxt.start = 1'b0;
          st_nxt.valid = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.wt <= 1'b1;
      st_r.fac <= FAC_RST; // R2 R9
      st_r.sfac <= FAC_RST;
      st_r.tol <= TOL_RST;
      st_r.swmin <= SWMIN_RST;
      st_r.swmax <= SWMAX_RST;
      st_r.lo <= SWMIN_RST;
      st_r.hi <= SWMAX_RST;
      st_r.job <= J_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  uus_div u_div (
    .clk(clk),
    .rst_b(rst_b),
    .start(st_r.start),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(quo)
  );

  assign readdata = st_r.rdata;
  assign waitrequest = st_r.wt;
  assign dem_pos = st_r.dem;
  assign spd_int = st_r.spd_i;
  assign acc_int = st_r.acc_i;
  assign jerk_int = st_r.jerk_i;
  assign conv_valid = st_r.valid;
  assign quick_stop = st_r.qstop;
  assign fault = st_r.fault;
  assign loop_tick = st_r.ltick;

  logic [LW-1:0] a_gap_r;
  logic a_seen_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      a_gap_r <= '0;
      a_seen_r <= 1'b0;
    end else if (st_r.ltick) begin
      a_gap_r <= '0;
      a_seen_r <= 1'b1;
    end else begin
      a_gap_r <= a_gap_r + 1'b1;
    end
  end

  property p_loop_gap;
    @(posedge clk) disable iff (!rst_b) (st_r.ltick && a_seen_r) |-> a_gap_r == LW'(LOOP_CYC - 1);
  endproperty
  a_loop_gap: assert property (p_loop_gap) else $error("loop tick spacing wrong"); // R18

  property p_den_nz;
    @(posedge clk) disable iff (!rst_b) st_r.start |-> div_den != '0;
  endproperty
  a_den_nz: assert property (p_den_nz) else $error("zero divisor reached the divider"); // R1

  property p_rst_fac;
    @(posedge clk) $rose(rst_b) |-> (st_r.fac[F_ENC] == ENC_RST && st_r.fac[F_MREV] == ONE);
  endproperty
  a_rst_fac: assert property (p_rst_fac) else $error("encoder factors not at defaults"); // R2

  property p_snap;
    @(posedge clk) disable iff (!rst_b)
      (ms_tick && st_r.job == J_IDLE) |=> (st_r.s_tgt == $past(st_r.tgt) && st_r.job == J_TGT);
  endproperty
  a_snap: assert property (p_snap) else $error("cycle tick did not capture inputs"); // R17

  property p_clamp;
    @(posedge clk) disable iff (!rst_b)
      (st_r.dem != $past(st_r.dem) && $signed(st_r.lo) <= $signed(st_r.hi))
      |-> ($signed(st_r.dem) >= $signed(st_r.lo) && $signed(st_r.dem) <= $signed(st_r.hi));
  endproperty
  a_clamp: assert property (p_clamp) else $error("demand position beyond limits"); // R15

  property p_toward;
    @(posedge clk) disable iff (!rst_b) $rose(st_r.rej) |-> $stable(st_r.dem);
  endproperty
  a_toward: assert property (p_toward) else $error("rejected target moved demand"); // R16

  property p_forbid;
    @(posedge clk) disable iff (!rst_b) (ms_tick && (neg_bad || pos_bad)) |=> (st_r.fault && st_r.qstop);
  endproperty
  a_forbid: assert property (p_forbid) else $error("forbidden range without stop"); // R14

  property p_jerk;
    @(posedge clk) disable iff (!rst_b)
      (st_r.valid && st_r.smode != MODE_PP && st_r.smode != MODE_PV) |-> st_r.jerk_i == '0;
  endproperty
  a_jerk: assert property (p_jerk) else $error("jerk applied outside profile modes"); // R11
endmodule // uus_top
`default_nettype wire

//--- verilog/uus_pkg.sv
// What this block does
// R1 - zero encoder increments or motor revolutions are used as 1
// R2 - after defaults encoder increments hold 2000 and motor revolutions 1
// R3 - positions use encoder increments per motor revolution as resolution
// R4 - gear ratio is motor over shaft revolutions, zero terms become 1
// R5 - feed constant is feed over axis revolutions, zero terms become 1
// R6 - position scale is increments times feed over revolutions times gear
// R7 - internal speed is user speed times numerator over denominator
// R8 - reported speed is internal speed divided by the speed factor
// R9 - speed numerator defaults to 1 and denominator to 60
// R10 - acceleration uses its own numerator over denominator, zeros become 1
// R11 - jerk uses its own factor, zeros become 1, only in profile modes
// R12 - an input acts as limit switch only when enabled
// R13 - free movement within a settable tolerance zone past the switch
// R14 - entering the forbidden range gives immediate stop and fault; the code checks for it only at each 1 ms tick
// R15 - demand position is clamped to the software limits
// R16 - outside the limits only moves toward the permitted range are taken
// R17 - values and inputs are sampled once per 1 ms cycle
// R18 - loop update tick runs at 32 kHz
// R19 - conversions round to nearest and are recomputed fresh each cycle
package uus_pkg;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYC = MS_NS / CLK_NS;
  localparam int unsigned LOOP_NS = 31250;
  localparam int unsigned LOOP_CYC = LOOP_NS / CLK_NS;
  localparam int VW = 32;
  localparam int FW = 16;
  localparam int DW = 48;
  localparam int NW = 80;
  localparam int CW = 7;
  localparam int LW = 12;
  localparam int AW = 5;
  localparam int MW = 8;
  localparam int BW = 4;
  localparam int BYTE = 8;
  localparam int NFAC = 12;
  localparam int F_ENC = 0;
  localparam int F_MREV = 1;
  localparam int F_GMOT = 2;
  localparam int F_GSHAFT = 3;
  localparam int F_FEED = 4;
  localparam int F_FSHAFT = 5;
  localparam int F_SNUM = 6;
  localparam int F_SDEN = 7;
  localparam int F_ANUM = 8;
  localparam int F_ADEN = 9;
  localparam int F_JNUM = 10;
  localparam int F_JDEN = 11;
  localparam int C_NEG_EN = 0;
  localparam int C_POS_EN = 1;
  localparam int C_FCLR = 2;
  localparam logic [FW-1:0] ONE = 16'h0001;
  localparam logic [FW-1:0] ENC_RST = 16'h07d0; // R2
  localparam logic [FW-1:0] SDEN_RST = 16'h003c; // R9
  localparam logic [NFAC-1:0][FW-1:0] FAC_RST = {ONE, ONE, ONE, ONE, SDEN_RST, ONE,
                                                 ONE, ONE, ONE, ONE, ONE, ENC_RST};
  localparam logic [VW-1:0] SWMIN_RST = 32'h80000000;
  localparam logic [VW-1:0] SWMAX_RST = 32'h7fffffff;
  localparam logic [VW-1:0] TOL_RST = 32'h00000000;
  localparam logic [VW-1:0] VMAX = 32'h7fffffff;
  localparam logic [VW-1:0] VNEG = 32'h80000000;
  localparam logic [MW-1:0] MODE_PP = 8'h01;
  localparam logic [MW-1:0] MODE_PV = 8'h03;
  localparam logic [AW-1:0] A_CTRL = 5'h00;
  localparam logic [AW-1:0] A_STAT = 5'h01;
  localparam logic [AW-1:0] A_FAC0 = 5'h02;
  localparam logic [AW-1:0] A_TOL = 5'h0e;
  localparam logic [AW-1:0] A_SWMIN = 5'h0f;
  localparam logic [AW-1:0] A_SWMAX = 5'h10;
  localparam logic [AW-1:0] A_TGT = 5'h11;
  localparam logic [AW-1:0] A_SPD = 5'h12;
  localparam logic [AW-1:0] A_ACC = 5'h13;
  localparam logic [AW-1:0] A_JERK = 5'h14;
  localparam logic [AW-1:0] A_MODE = 5'h15;
  localparam logic [AW-1:0] A_APOS = 5'h16;
  localparam logic [AW-1:0] A_ASPD = 5'h17;
  localparam logic [AW-1:0] A_DEM = 5'h18;

  typedef enum logic [2:0] {J_IDLE, J_TGT, J_APOS, J_SPD, J_ASPD, J_ACC, J_JERK} uus_job_t;

  function automatic logic [FW-1:0] uus_nz(input logic [FW-1:0] x);
    return (x == '0) ? ONE : x; // R1 R4 R5 R10 R11
  endfunction

  function automatic logic [VW-1:0] uus_bemerge(input logic [VW-1:0] old, input logic [VW-1:0] wd,
                                                input logic [BW-1:0] be);
    logic [VW-1:0] r;
    r = old;
    for (int i = 0; i < BW; i++) begin
      if (be[i]) r[i*BYTE +: BYTE] = wd[i*BYTE +: BYTE];
    end
    return r;
  endfunction
endpackage

//--- verilog/uus_div.sv
`timescale 1ns/1ns
`default_nettype none
module uus_div
  import uus_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic done,
  output logic [NW-1:0] quo
);
  typedef struct packed {
    logic [DW:0] rem;
    logic [NW-1:0] q;
    logic [CW-1:0] cnt;
    logic busy;
    logic done;
  } uus_div_t;

  uus_div_t st_r;
  uus_div_t st_nxt;
  logic [DW:0] trial;

  // restoring division, one quotient bit per clock; den must stay put while busy
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    trial = {st_r.rem[DW-1:0], st_r.q[NW-1]};
    if (start) begin
      st_nxt.rem = '0;
      st_nxt.q = num;
      st_nxt.cnt = '0;
      st_nxt.busy = 1'b1;
    end else if (st_r.busy) begin
      if (trial >= {1'b0, den}) begin
        st_nxt.rem = trial - {1'b0, den};
        st_nxt.q = {st_r.q[NW-2:0], 1'b1};
      end else begin
        st_nxt.rem = trial;
        st_nxt.q = {st_r.q[NW-2:0], 1'b0};
      end
      st_nxt.cnt = st_r.cnt + 1'b1;
      if (st_r.cnt == CW'(NW - 1)) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
  assign quo = st_r.q;

  property p_div_lat;
    @(posedge clk) disable iff (!rst_b) start |-> ##81 st_r.done;
  endproperty
  a_div_lat: assert property (p_div_lat) else $error("divider did not finish in 81 cycles");

  property p_div_rem;
    @(posedge clk) disable iff (!rst_b) st_r.done |-> st_r.rem < {1'b0, den};
  endproperty
  a_div_rem: assert property (p_div_rem) else $error("divider remainder not below divisor"); // R19
endmodule // uus_div
`default_nettype wire

//--- dv/uus_drive_model.sv
`timescale 1ns/1ns
`default_nettype none
// motor side: feedback and switch levels follow what the bench commands, one edge later
module uus_drive_model
  import uus_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [VW-1:0] set_pos,
  input wire logic [VW-1:0] set_spd,
  input wire logic set_neg,
  input wire logic set_posl,
  output logic [VW-1:0] act_pos_in,
  output logic [VW-1:0] act_spd_in,
  output logic lim_neg_in,
  output logic lim_pos_in
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_pos_in <= '0;
      act_spd_in <= '0;
      lim_neg_in <= 1'b0;
      lim_pos_in <= 1'b0;
    end else begin
      act_pos_in <= set_pos;
      act_spd_in <= set_spd;
      lim_neg_in <= set_neg;
      lim_pos_in <= set_posl;
    end
  end
endmodule // uus_drive_model
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import uus_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [AW-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [VW-1:0] writedata = '0;
  logic [BW-1:0] byteenable = '0;
  logic [VW-1:0] readdata, dem_pos, spd_int, acc_int, jerk_int, act_pos_in, act_spd_in;
  logic waitrequest, lim_neg_in, lim_pos_in, conv_valid, quick_stop, fault, loop_tick;
  logic [VW-1:0] m_pos = '0;
  logic [VW-1:0] m_spd = '0;
  logic m_neg = 1'b0;
  logic m_posl = 1'b0;
  int n_fail = 0;
  int num_checks = 0;
  int n_qs = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (quick_stop === 1'b1) n_qs <= n_qs + 1;

  uus_top #(.MS_CYC_P(1000)) u_dut (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .act_pos_in(act_pos_in), .act_spd_in(act_spd_in), .lim_neg_in(lim_neg_in), .lim_pos_in(lim_pos_in),
    .dem_pos(dem_pos), .spd_int(spd_int), .acc_int(acc_int), .jerk_int(jerk_int), .conv_valid(conv_valid),
    .quick_stop(quick_stop), .fault(fault), .loop_tick(loop_tick));
  uus_drive_model u_drv (.clk(clk), .rst_b(rst_b), .set_pos(m_pos), .set_spd(m_spd), .set_neg(m_neg),
    .set_posl(m_posl), .act_pos_in(act_pos_in), .act_spd_in(act_spd_in), .lim_neg_in(lim_neg_in),
    .lim_pos_in(lim_pos_in));

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [VW-1:0] got, input logic [VW-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; one idle edge at the end keeps strobes from being set twice at once
  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [VW-1:0] d, output logic [VW-1:0] q);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    byteenable <= 4'hf;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_fail++;
      $display("FAIL at %0t: bus answer timed out", $time);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [VW-1:0] d);
    logic [VW-1:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [VW-1:0] mask, input logic [VW-1:0] exp);
    logic [VW-1:0] q;
    bus(1'b0, a, '0, q);
    chk(q & mask, exp);
  endtask

  // two chains: the second one surely snapshots after the last write
  task automatic wait_conv(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (conv_valid !== 1'b1 && n < 1500);
      if (n >= 1500) begin
        n_fail++;
        $display("FAIL at %0t: conversion chain timed out", $time);
      end
    end
  endtask

  task automatic t_reset();
    for (int i = 0; i < NFAC; i++)
      rd(A_FAC0 + AW'(i), '1, (i == F_ENC) ? 32'h000007d0 : (i == F_SDEN) ? 32'h0000003c : 32'h00000001);
    rd(A_SWMIN, '1, 32'h80000000);
    rd(A_SWMAX, '1, 32'h7fffffff);
    rd(5'h1f, '1, 32'h00000000);
    wr(A_STAT, 32'hffffffff);
    rd(A_STAT, 32'h0000000f, 32'h00000000);
  endtask

  task automatic t_speed();
    m_spd <= 32'h00000005;
    wr(A_SPD, 32'd300);
    wait_conv(2);
    chk(spd_int, 32'h00000005);
    rd(A_ASPD, '1, 32'd300);
    wr(A_SPD, 32'd90);
    wait_conv(2);
    chk(spd_int, 32'h00000002);
    wr(A_SPD, -32'sd90);
    wait_conv(2);
    chk(spd_int, 32'hfffffffe);
  endtask

  task automatic t_acc_jerk();
    logic [MW-1:0] modes [3] = '{MODE_PP, MODE_PV, 8'h06};
    logic [VW-1:0] exps [3] = '{32'd15, 32'd15, 32'd0};
    wr(A_FAC0 + AW'(F_ANUM), '0);
    wr(A_FAC0 + AW'(F_ADEN), '0);
    wr(A_FAC0 + AW'(F_JNUM), 32'd3);
    wr(A_FAC0 + AW'(F_JDEN), '0);
    wr(A_ACC, 32'd13);
    wr(A_JERK, 32'd5);
    for (int i = 0; i < 3; i++) begin
      wr(A_MODE, {24'h0, modes[i]});
      wait_conv(2);
      chk(acc_int, 32'd13);
      chk(jerk_int, exps[i]);
    end
  endtask

  task automatic t_pos();
    // scale 2000*3*1 / (1*2*4) = 750 increments per user unit, shaft term 0 taken as 1
    wr(A_FAC0 + AW'(F_FEED), 32'd3);
    wr(A_FAC0 + AW'(F_FSHAFT), 32'd2);
    wr(A_FAC0 + AW'(F_GMOT), 32'd4);
    wr(A_FAC0 + AW'(F_GSHAFT), '0);
    wr(A_TGT, 32'd4);
    m_pos <= 32'd3000;
    wait_conv(2);
    chk(dem_pos, 32'd3000);
    rd(A_APOS, '1, 32'd4);
    rd(A_DEM, '1, 32'd3000);
    wr(A_FAC0 + AW'(F_ENC), '0);
    wr(A_FAC0 + AW'(F_MREV), '0);
    wr(A_TGT, 32'd16);
    wait_conv(2);
    chk(dem_pos, 32'd6);
    rd(A_APOS, '1, 32'd8000);
    // back to unit scale through zero terms
    wr(A_FAC0 + AW'(F_FEED), '0);
    wr(A_FAC0 + AW'(F_FSHAFT), '0);
    wr(A_FAC0 + AW'(F_GMOT), '0);
  endtask

  task automatic t_swlim();
    m_pos <= '0;
    wr(A_SWMAX, 32'd1000);
    wr(A_SWMIN, -32'sd1000);
    wr(A_TGT, 32'd5000);
    wait_conv(2);
    chk(dem_pos, 32'd1000);
    wr(A_TGT, -32'sd5000);
    wait_conv(2);
    chk(dem_pos, 32'hfffffc18);
    m_pos <= 32'd5000;
    wr(A_TGT, 32'd500);
    wait_conv(2);
    chk(dem_pos, 32'd500);
    wr(A_TGT, 32'd6000);
    wait_conv(2);
    chk(dem_pos, 32'd500);
    rd(A_STAT, 32'h00000008, 32'h00000008);
    m_pos <= '0;
    wr(A_SWMAX, 32'h7fffffff);
    wr(A_SWMIN, 32'h80000000);
    wr(A_CTRL, 32'h00000004);
    rd(A_STAT, 32'h00000008, 32'h00000000);
  endtask

  task automatic t_limit();
    wr(A_TOL, 32'd50);
    m_pos <= 32'd300;
    m_posl <= 1'b1;
    wait_conv(2);
    chk({31'h0, fault}, 32'h0);
    rd(A_STAT, 32'h00000004, 32'h00000000);
    m_pos <= 32'd100;
    wait_conv(1);
    wr(A_CTRL, 32'h00000002);
    wait_conv(2);
    m_pos <= 32'd140;
    wait_conv(2);
    chk({31'h0, fault}, 32'h0);
    rd(A_STAT, 32'h00000004, 32'h00000004);
    chk(n_qs, 32'h0);
    m_pos <= 32'd200;
    // the stop repeats at every tick spent beyond the zone, so look after the first one
    wait_conv(1);
    chk({31'h0, fault}, 32'h1);
    chk(n_qs, 32'h1);
    rd(A_STAT, 32'h00000001, 32'h00000001);
    m_posl <= 1'b0;
    m_neg <= 1'b1;
    m_pos <= '0;
    wr(A_CTRL, 32'h00000005);
    wait_conv(2);
    chk({31'h0, fault}, 32'h0);
    rd(A_STAT, 32'h00000002, 32'h00000002);
    m_pos <= -32'sd60;
    wait_conv(1);
    chk({31'h0, fault}, 32'h1);
    chk(n_qs, 32'h2);
    m_neg <= 1'b0;
    wr(A_CTRL, 32'h00000004);
    chk({31'h0, fault}, 32'h0);
  endtask

  task automatic t_timing();
    int n;
    longint t0;
    wait_conv(1);
    t0 = $time;
    wait_conv(1);
    chk(32'(($time - t0) / 10), 32'd1000);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (loop_tick !== 1'b1 && n < 4000);
      if (k == 1) chk(32'(($time - t0) / 10), 32'd3125);
      t0 = $time;
    end
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, waitrequest}, 32'h1);
    t_reset();
    t_speed();
    t_acc_jerk();
    t_pos();
    t_swlim();
    t_limit();
    t_timing();
    finish_test();
  end

  // run needs well under 70000 cycles
  initial begin
    #700000;
    n_fail++;
    $display("FAIL at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
